// [cpu_regs_pkg.sv]
// Shared constants for the processor register set core
package cpu_regs_pkg;
   // Command codes on the command port
   localparam logic [3:0] OP_NOP     = 4'h0;
   localparam logic [3:0] OP_RD8     = 4'h1;
   localparam logic [3:0] OP_WR8     = 4'h2;
   localparam logic [3:0] OP_RD16    = 4'h3;
   localparam logic [3:0] OP_WR16    = 4'h4;
   localparam logic [3:0] OP_EX_AF   = 4'h5;
   localparam logic [3:0] OP_EXX     = 4'h6;
   localparam logic [3:0] OP_INT_CFG = 4'h7;
   localparam logic [3:0] OP_INT_ACK = 4'h8;
   localparam logic [3:0] OP_PUSH    = 4'h9;
   localparam logic [3:0] OP_POP     = 4'ha;
   localparam logic [3:0] OP_INDEX   = 4'hb;
   localparam logic [3:0] OP_BLOCK   = 4'hc;
   localparam logic [3:0] OP_BIT     = 4'hd;

   // 16-bit selectors; 0..3 live in the banked store
   localparam logic [3:0] SEL16_AF = 4'h0;
   localparam logic [3:0] SEL16_BC = 4'h1;
   localparam logic [3:0] SEL16_DE = 4'h2;
   localparam logic [3:0] SEL16_HL = 4'h3;
   localparam logic [3:0] SEL16_SP = 4'h4;
   localparam logic [3:0] SEL16_IX = 4'h5;
   localparam logic [3:0] SEL16_IY = 4'h6;
   localparam logic [3:0] SEL16_PC = 4'h7;
   // 8-bit selectors: sel[2:1] pair, sel[0] low byte; then vector base and refresh
   localparam logic [3:0] SEL8_FIRST_SPECIAL = 4'h8;
   localparam logic [3:0] SEL8_VEC_BASE      = 4'h8;
   localparam logic [3:0] SEL8_REFRESH       = 4'h9;

   // Interrupt response modes
   localparam logic [1:0] IM_LEGACY   = 2'h0;
   localparam logic [1:0] IM_GENERIC  = 2'h1;
   localparam logic [1:0] IM_VECTORED = 2'h2;
   localparam logic [1:0] IM_RESET    = 2'h0;
   // Fixed service address for generic-peripheral mode; plain default
   localparam logic [15:0] GENERIC_INT_ADDR = 16'h0000;
   localparam int          CFG_ENABLE_BIT   = 2;

   // Bit operations in CMD_DATA[9:8]
   localparam logic [1:0] BITOP_TEST  = 2'h1;
   localparam logic [1:0] BITOP_SET   = 2'h2;
   localparam logic [1:0] BITOP_RESET = 2'h3;

   // Block operation options in CMD_DATA
   localparam int         BLK_DEC_BIT    = 0;
   localparam int         BLK_SEARCH_BIT = 1;
   localparam logic [2:0] BLK_LAST_STEP  = 3'h6;

   localparam logic [15:0] STACK_STEP  = 16'h0002;
   localparam logic [15:0] WORD_RESET  = 16'h0000;
   localparam logic [7:0]  BYTE_RESET  = 8'h00;
   localparam int          STORE_WORDS = 8;
endpackage

// [regstore_if.sv]
// Connection between the control logic and the banked register store
`timescale 1ns/1ps
`default_nettype none
interface regstore_if;
   logic        ce;
   logic [2:0]  rd_addr;
   logic [15:0] rd_data;
   logic        wr_en;
   logic [1:0]  wr_be;
   logic [2:0]  wr_addr;
   logic [15:0] wr_data;
   modport ctrl (output ce, rd_addr, wr_en, wr_be, wr_addr, wr_data, input rd_data);
   modport store (input ce, rd_addr, wr_en, wr_be, wr_addr, wr_data, output rd_data);
endinterface
`default_nettype wire

// [bank_store.sv]
// Banked register store: main and alternate AF, BC, DE, HL words
`timescale 1ns/1ps
`default_nettype none
module bank_store
(
   input  wire logic   clk,
   input  wire logic   rst,
   regstore_if.store   bus
);
   logic [15:0] word [cpu_regs_pkg::STORE_WORDS];

   // One word per entry, high and low byte written separately
   genvar g;
   generate
      for (g = 0; g < cpu_regs_pkg::STORE_WORDS; g++)
      begin : g_word
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
               word[g] <= cpu_regs_pkg::WORD_RESET;
            else if (bus.ce && bus.wr_en && bus.wr_addr == 3'(g))
            begin
               if (bus.wr_be[1])
                  word[g][15:8] <= bus.wr_data[15:8];
               if (bus.wr_be[0])
                  word[g][7:0] <= bus.wr_data[7:0];
            end
         end
      end
   endgenerate

   // Registered read port
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         bus.rd_data <= cpu_regs_pkg::WORD_RESET;
      else if (bus.ce)
         bus.rd_data <= word[bus.rd_addr];
   end
endmodule
`default_nettype wire

// [cpu_register_set_core.sv]
// Programmer-visible register set, exchange, stack, index, refresh and interrupt vectoring
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Two banks of six byte registers, reachable as bytes or as pairs.
// - Accumulator and flags exist twice, one copy per bank.
// - Exchange commands flip which bank is visible, without memory traffic.
// - One 16-bit stack pointer moves by two on push, pop and interrupt acknowledge.
// - Two 16-bit index registers plus signed displacement give operand addresses.
// - Refresh counter's low seven bits step on every opcode fetch; a byte write to the refresh selector loads it instead.
// - Vectored mode: peripheral gives low byte, vector base gives high byte.
// - Three interrupt modes: legacy, generic peripheral, vectored daisy chain.
// - Storage totals 208 bits: banks, SP, IX, IY, PC, vector, refresh.
// - Bus request granted on the pins at a bus-idle point, no glue.
// - Block move/search steps and bit set, reset, test on any byte.
module cpu_register_set_core
(
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        CE,
   input  wire logic        CMD_VALID,
   input  wire logic [3:0]  CMD_OP,
   input  wire logic [3:0]  CMD_SEL,
   input  wire logic [15:0] CMD_DATA,
   input  wire logic        FETCH,
   input  wire logic        BUSREQ_N,
   input  wire logic        BUS_IDLE,
   input  wire logic        INT_N,
   output logic             CMD_READY,
   output logic             CMD_DONE,
   output logic [15:0]      RD_DATA,
   output logic [15:0]      AUX_DATA,
   output logic             FLAG_ZERO,
   output logic             FLAG_MATCH,
   output logic             FLAG_COUNT_NZ,
   output logic [15:0]      REFRESH_ADDR,
   output logic [1:0]       BANK_STATE,
   output logic             BUSACK_N,
   output logic             INT_PENDING
);
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_BLOCK} state_e;

   state_e      state, next_state;
   logic [15:0] sp, ix, iy, pc;
   logic [7:0]  vec_base, refresh;
   logic        af_bank, gp_bank, int_enable, accept, sel_byte;
   logic [1:0]  int_mode, blk_pair;
   logic [3:0]  lat_sel;
   logic [15:0] lat_data;
   logic [2:0]  blk_step;
   logic [15:0] blk_bc, blk_de, blk_hl;
   logic [15:0] next_bc, next_de, next_hl;
   logic [7:0]  bit_mask;
   logic [15:0] disp;

   regstore_if store_bus ();

   bank_store u_store
   (
      .clk (CLK),
      .rst (RST),
      .bus (store_bus)
   );

   // Store word address of a pair in the visible bank
   function automatic logic [2:0] word_addr(input logic [1:0] pair, input logic afb,
                                            input logic gpb);
      word_addr = {(pair == 2'h0) ? afb : gpb, pair};
   endfunction

   assign accept   = CMD_VALID && state == ST_IDLE;
   assign next_bc  = blk_bc - 16'h0001;
   assign next_hl  = lat_data[cpu_regs_pkg::BLK_DEC_BIT] ? blk_hl - 16'h0001 : blk_hl + 16'h0001;
   assign next_de  = lat_data[cpu_regs_pkg::BLK_DEC_BIT] ? blk_de - 16'h0001 : blk_de + 16'h0001;
   assign bit_mask = 8'h01 << CMD_SEL[2:0];
   assign blk_pair = blk_step[1:0] + 2'h1;
   assign disp     = {{8{CMD_DATA[7]}}, CMD_DATA[7:0]};

   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
            if (accept)
            begin
               if ((CMD_OP == cpu_regs_pkg::OP_RD8 && CMD_SEL < cpu_regs_pkg::SEL8_FIRST_SPECIAL)
                   || (CMD_OP == cpu_regs_pkg::OP_RD16 && CMD_SEL < cpu_regs_pkg::SEL16_SP))
                  next_state = ST_READ;
               else if (CMD_OP == cpu_regs_pkg::OP_BLOCK)
                  next_state = ST_BLOCK;
            end
         ST_READ:
            next_state = ST_IDLE;
         ST_BLOCK:
            if (blk_step == cpu_regs_pkg::BLK_LAST_STEP)
               next_state = ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         state     <= ST_IDLE;
         CMD_READY <= 1'b0;
      end
      else if (CE)
      begin
         state     <= next_state;
         CMD_READY <= next_state == ST_IDLE;
      end
   end

   // Store port: bank reads and writes, block steps
   always_comb
   begin
      store_bus.ce      = CE;
      store_bus.rd_addr = word_addr(CMD_SEL[1:0], af_bank, gp_bank);
      store_bus.wr_en   = 1'b0;
      store_bus.wr_be   = 2'b11;
      store_bus.wr_addr = word_addr(CMD_SEL[1:0], af_bank, gp_bank);
      store_bus.wr_data = CMD_DATA;
      if (accept)
      begin
         case (CMD_OP)
            cpu_regs_pkg::OP_RD8:
               store_bus.rd_addr = word_addr(CMD_SEL[2:1], af_bank, gp_bank);
            cpu_regs_pkg::OP_WR8:
               if (CMD_SEL < cpu_regs_pkg::SEL8_FIRST_SPECIAL)
               begin
                  store_bus.wr_en   = 1'b1;
                  store_bus.wr_addr = word_addr(CMD_SEL[2:1], af_bank, gp_bank);
                  store_bus.wr_be   = CMD_SEL[0] ? 2'b01 : 2'b10;
                  store_bus.wr_data = {CMD_DATA[7:0], CMD_DATA[7:0]};
               end
            cpu_regs_pkg::OP_WR16:
               store_bus.wr_en = CMD_SEL < cpu_regs_pkg::SEL16_SP;
            default:
               store_bus.wr_en = 1'b0;
         endcase
      end
      else if (state == ST_BLOCK)
      begin
         // Steps 0..3 read BC, DE, HL, AF; steps 4..6 write BC, DE, HL
         store_bus.rd_addr = word_addr(blk_pair, af_bank, gp_bank);
         store_bus.wr_addr = word_addr(blk_pair, af_bank, gp_bank);
         case (blk_step)
            3'h4:
            begin
               store_bus.wr_en   = 1'b1;
               store_bus.wr_data = next_bc;
            end
            3'h5:
            begin
               // Search leaves the destination pointer alone
               store_bus.wr_en   = !lat_data[cpu_regs_pkg::BLK_SEARCH_BIT];
               store_bus.wr_data = next_de;
            end
            3'h6:
            begin
               store_bus.wr_en   = 1'b1;
               store_bus.wr_data = next_hl;
            end
            default:
               store_bus.wr_en = 1'b0;
         endcase
      end
   end

   // Command capture and block sequencing
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         lat_sel  <= 4'h0;
         sel_byte <= 1'b0;
         lat_data <= cpu_regs_pkg::WORD_RESET;
         blk_step <= 3'h0;
         blk_bc   <= cpu_regs_pkg::WORD_RESET;
         blk_de   <= cpu_regs_pkg::WORD_RESET;
         blk_hl   <= cpu_regs_pkg::WORD_RESET;
      end
      else if (CE)
      begin
         if (accept)
         begin
            lat_sel  <= CMD_SEL;
            sel_byte <= CMD_OP == cpu_regs_pkg::OP_RD8;
            lat_data <= CMD_DATA;
            blk_step <= 3'h0;
         end
         else if (state == ST_BLOCK)
         begin
            blk_step <= blk_step + 3'h1;
            if (blk_step == 3'h1)
               blk_bc <= store_bus.rd_data;
            if (blk_step == 3'h2)
               blk_de <= store_bus.rd_data;
            if (blk_step == 3'h3)
               blk_hl <= store_bus.rd_data;
         end
      end
   end

   // Bank visibility flips
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         af_bank <= 1'b0;
         gp_bank <= 1'b0;
      end
      else if (CE && accept)
      begin
         if (CMD_OP == cpu_regs_pkg::OP_EX_AF)
            af_bank <= !af_bank;
         if (CMD_OP == cpu_regs_pkg::OP_EXX)
            gp_bank <= !gp_bank;
      end
   end

   // Stack pointer, index registers, program counter
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         sp <= cpu_regs_pkg::WORD_RESET;
         ix <= cpu_regs_pkg::WORD_RESET;
         iy <= cpu_regs_pkg::WORD_RESET;
         pc <= cpu_regs_pkg::WORD_RESET;
      end
      else if (CE && accept)
      begin
         case (CMD_OP)
            cpu_regs_pkg::OP_PUSH, cpu_regs_pkg::OP_INT_ACK:
               sp <= sp - cpu_regs_pkg::STACK_STEP;
            cpu_regs_pkg::OP_POP:
               sp <= sp + cpu_regs_pkg::STACK_STEP;
            cpu_regs_pkg::OP_WR16:
               case (CMD_SEL)
                  cpu_regs_pkg::SEL16_SP: sp <= CMD_DATA;
                  cpu_regs_pkg::SEL16_IX: ix <= CMD_DATA;
                  cpu_regs_pkg::SEL16_IY: iy <= CMD_DATA;
                  cpu_regs_pkg::SEL16_PC: pc <= CMD_DATA;
                  default: sp <= sp;
               endcase
            default:
               sp <= sp;
         endcase
      end
   end

   // Vector base and refresh counter; a write beats a fetch step
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         vec_base <= cpu_regs_pkg::BYTE_RESET;
         refresh  <= cpu_regs_pkg::BYTE_RESET;
      end
      else if (CE)
      begin
         if (accept && CMD_OP == cpu_regs_pkg::OP_WR8 && CMD_SEL == cpu_regs_pkg::SEL8_VEC_BASE)
            vec_base <= CMD_DATA[7:0];
         if (accept && CMD_OP == cpu_regs_pkg::OP_WR8 && CMD_SEL == cpu_regs_pkg::SEL8_REFRESH)
            refresh <= CMD_DATA[7:0];
         else if (FETCH)
            refresh <= {refresh[7], refresh[6:0] + 7'h01};
      end
   end

   // Interrupt mode, enable and pending level
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         int_mode    <= cpu_regs_pkg::IM_RESET;
         int_enable  <= 1'b0;
         INT_PENDING <= 1'b0;
      end
      else if (CE)
      begin
         if (accept && CMD_OP == cpu_regs_pkg::OP_INT_CFG)
         begin
            if (CMD_DATA[1:0] != 2'h3)
               int_mode <= CMD_DATA[1:0];
            int_enable <= CMD_DATA[cpu_regs_pkg::CFG_ENABLE_BIT];
         end
         else if (accept && CMD_OP == cpu_regs_pkg::OP_INT_ACK)
            int_enable <= 1'b0;
         INT_PENDING <= !INT_N && int_enable;
      end
   end

   // Bus grant at a bus-idle point, released when the request drops
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         BUSACK_N <= 1'b1;
      else if (CE)
      begin
         if (BUSREQ_N)
            BUSACK_N <= 1'b1;
         else if (BUS_IDLE)
            BUSACK_N <= 1'b0;
      end
   end

   // Status mirrors
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         REFRESH_ADDR <= cpu_regs_pkg::WORD_RESET;
         BANK_STATE   <= 2'h0;
      end
      else if (CE)
      begin
         REFRESH_ADDR <= {vec_base, refresh};
         BANK_STATE   <= {gp_bank, af_bank};
      end
   end

   // Results
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         CMD_DONE      <= 1'b0;
         RD_DATA       <= cpu_regs_pkg::WORD_RESET;
         AUX_DATA      <= cpu_regs_pkg::WORD_RESET;
         FLAG_ZERO     <= 1'b0;
         FLAG_MATCH    <= 1'b0;
         FLAG_COUNT_NZ <= 1'b0;
      end
      else if (CE)
      begin
         CMD_DONE <= 1'b0;
         if (state == ST_READ)
         begin
            CMD_DONE <= 1'b1;
            if (sel_byte)
               RD_DATA <= {8'h00, lat_sel[0] ? store_bus.rd_data[7:0]
                                             : store_bus.rd_data[15:8]};
            else
               RD_DATA <= store_bus.rd_data;
         end
         else if (state == ST_BLOCK)
         begin
            if (blk_step == 3'h4)
            begin
               FLAG_MATCH    <= store_bus.rd_data[15:8] == lat_data[15:8];
               FLAG_COUNT_NZ <= next_bc != 16'h0000;
            end
            if (blk_step == cpu_regs_pkg::BLK_LAST_STEP)
            begin
               CMD_DONE <= 1'b1;
               RD_DATA  <= blk_hl;
               AUX_DATA <= blk_de;
            end
         end
         else if (accept && next_state == ST_IDLE)
         begin
            CMD_DONE <= 1'b1;
            case (CMD_OP)
               cpu_regs_pkg::OP_RD8:
                  RD_DATA <= {8'h00, CMD_SEL == cpu_regs_pkg::SEL8_VEC_BASE ? vec_base : refresh};
               cpu_regs_pkg::OP_RD16:
                  case (CMD_SEL)
                     cpu_regs_pkg::SEL16_SP: RD_DATA <= sp;
                     cpu_regs_pkg::SEL16_IX: RD_DATA <= ix;
                     cpu_regs_pkg::SEL16_IY: RD_DATA <= iy;
                     default:                RD_DATA <= pc;
                  endcase
               cpu_regs_pkg::OP_PUSH:
                  RD_DATA <= sp - cpu_regs_pkg::STACK_STEP;
               cpu_regs_pkg::OP_POP:
                  RD_DATA <= sp;
               cpu_regs_pkg::OP_INDEX:
                  RD_DATA <= (CMD_SEL[0] ? iy : ix) + disp;
               cpu_regs_pkg::OP_INT_ACK:
               begin
                  AUX_DATA <= pc;
                  case (int_mode)
                     cpu_regs_pkg::IM_GENERIC:  RD_DATA <= cpu_regs_pkg::GENERIC_INT_ADDR;
                     cpu_regs_pkg::IM_VECTORED: RD_DATA <= {vec_base, CMD_DATA[7:0]};
                     default:                   RD_DATA <= {8'h00, CMD_DATA[7:0]};
                  endcase
               end
               cpu_regs_pkg::OP_BIT:
               begin
                  FLAG_ZERO <= (CMD_DATA[7:0] & bit_mask) == 8'h00;
                  case (CMD_DATA[9:8])
                     cpu_regs_pkg::BITOP_SET:   RD_DATA <= {8'h00, CMD_DATA[7:0] | bit_mask};
                     cpu_regs_pkg::BITOP_RESET: RD_DATA <= {8'h00, CMD_DATA[7:0] & ~bit_mask};
                     default:                   RD_DATA <= {8'h00, CMD_DATA[7:0]};
                  endcase
               end
               default:
                  RD_DATA <= RD_DATA;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// [cpu_register_set_core_assertions.sv]
// Port checks for the register set core
`timescale 1ns/1ps
`default_nettype none
module cpu_register_set_core_assertions
(
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        CE,
   input  wire logic        CMD_VALID,
   input  wire logic [3:0]  CMD_OP,
   input  wire logic [3:0]  CMD_SEL,
   input  wire logic        FETCH,
   input  wire logic        BUSREQ_N,
   input  wire logic        BUS_IDLE,
   input  wire logic        INT_N,
   input  wire logic        CMD_READY,
   input  wire logic        CMD_DONE,
   input  wire logic [15:0] REFRESH_ADDR,
   input  wire logic [1:0]  BANK_STATE,
   input  wire logic        BUSACK_N,
   input  wire logic        INT_PENDING
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   sequence s_take(o, c);
      CE && CMD_VALID && CMD_READY && CMD_OP == o && c;
   endsequence
   sequence s_quiet(f);
      CE && !CMD_VALID && FETCH == f;
   endsequence

   property p_rd_bank;
      s_take(cpu_regs_pkg::OP_RD16, CMD_SEL < 4'h4) |=> !CMD_READY ##1 CMD_DONE && CMD_READY;
   endproperty
   a_rd_bank: assert property (p_rd_bank)
      else $error("banked read timing wrong");

   property p_direct;
      s_take(cpu_regs_pkg::OP_WR16, 1'b1) |=> CMD_DONE && CMD_READY;
   endproperty
   a_direct: assert property (p_direct)
      else $error("write not done next cycle");

   property p_block;
      s_take(cpu_regs_pkg::OP_BLOCK, 1'b1) |=> (!CMD_DONE && !CMD_READY)[*7] ##1 CMD_DONE;
   endproperty
   a_block: assert property (p_block)
      else $error("block step length wrong");

   property p_exx;
      s_take(cpu_regs_pkg::OP_EXX, 1'b1) |=> ##1
         BANK_STATE == {~$past(BANK_STATE[1], 2), $past(BANK_STATE[0], 2)};
   endproperty
   a_exx: assert property (p_exx)
      else $error("exchange did not flip bank");

   property p_refresh;
      s_quiet(1'b0) ##1 s_quiet(1'b1) ##1 s_quiet(1'b0) |=>
         REFRESH_ADDR[6:0] == $past(REFRESH_ADDR[6:0], 2) + 7'h01
         && REFRESH_ADDR[7] == $past(REFRESH_ADDR[7], 2);
   endproperty
   a_refresh: assert property (p_refresh)
      else $error("refresh step wrong");

   property p_grant;
      CE && !BUSREQ_N && BUS_IDLE |=> !BUSACK_N;
   endproperty
   a_grant: assert property (p_grant)
      else $error("bus not granted");

   property p_release;
      CE && BUSREQ_N |=> BUSACK_N;
   endproperty
   a_release: assert property (p_release)
      else $error("bus grant not released");

   property p_int_off;
      CE && INT_N |=> !INT_PENDING;
   endproperty
   a_int_off: assert property (p_int_off)
      else $error("interrupt pending without request");
endmodule

bind cpu_register_set_core cpu_register_set_core_assertions u_chk (.*);
`default_nettype wire

// [sys_bus_model.sv]
// Model of memory and peripheral controllers on the system bus
`timescale 1ns/1ps
`default_nettype none
module sys_bus_model
(
   input  wire logic  clk,
   input  wire logic  rst,
   input  wire logic  want_bus,
   input  wire logic  raise_int,
   input  wire logic  fetch_go,
   input  wire logic  busack_n,
   output logic       busreq_n,
   output logic       bus_idle,
   output logic       int_n,
   output logic       fetch,
   output logic [7:0] vec_lo
);
   logic [1:0] phase;
   assign vec_lo = 8'h5a;
   assign bus_idle = phase == 2'h3;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         phase    <= 2'h0;
         busreq_n <= 1'b1;
         int_n    <= 1'b1;
         fetch    <= 1'b0;
      end
      else
      begin
         // No own bus cycles while the bus is handed over
         phase    <= busack_n ? phase + 2'h1 : phase;
         busreq_n <= !want_bus;
         int_n    <= !raise_int;
         fetch    <= fetch_go;
      end
   end
endmodule
`default_nettype wire

// [cpu_register_set_core_tb_top.sv]
// Self-checking bench for the register set core
`timescale 1ns/1ps
`default_nettype none
module cpu_register_set_core_tb_top;
   logic        clk, rst, valid, want_bus, raise_int, fetch_go, fetch, busreq_n, bus_idle;
   logic        int_n, ready, done, fz, fm, fnz, back_n, pend;
   logic [3:0]  op, sel;
   logic [15:0] dat, rd, aux, rfa;
   logic [1:0]  bank;
   logic [7:0]  vec_lo;
   int          err_count = 0, compares = 0, cyc = 0, lat;

   cpu_register_set_core dut
   (
      .CLK(clk), .RST(rst), .CE(1'b1), .CMD_VALID(valid), .CMD_OP(op), .CMD_SEL(sel),
      .CMD_DATA(dat), .FETCH(fetch), .BUSREQ_N(busreq_n), .BUS_IDLE(bus_idle),
      .INT_N(int_n), .CMD_READY(ready), .CMD_DONE(done), .RD_DATA(rd), .AUX_DATA(aux),
      .FLAG_ZERO(fz), .FLAG_MATCH(fm), .FLAG_COUNT_NZ(fnz), .REFRESH_ADDR(rfa),
      .BANK_STATE(bank), .BUSACK_N(back_n), .INT_PENDING(pend)
   );
   sys_bus_model bus
   (
      .clk(clk), .rst(rst), .want_bus(want_bus), .raise_int(raise_int),
      .fetch_go(fetch_go), .busack_n(back_n), .busreq_n(busreq_n),
      .bus_idle(bus_idle), .int_n(int_n), .fetch(fetch), .vec_lo(vec_lo)
   );

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         err_count++;
         final_report();
      end
   end

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR %0t got %h want %h", $time, g, e);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Present one command, wait for its done pulse and check the latency
   task automatic cmd(input logic [3:0] o, input logic [3:0] s, input logic [15:0] d,
                      input int l);
      lat = 0;
      while (ready !== 1'b1 && lat < 50)
      begin
         tick(1);
         lat++;
      end
      @(posedge clk);
      valid <= 1'b1;
      op <= o;
      sel <= s;
      dat <= d;
      @(posedge clk);
      valid <= 1'b0;
      #1;
      lat = 0;
      while (done !== 1'b1 && lat < 20)
      begin
         tick(1);
         lat++;
      end
      chk(16'(lat), 16'(l));
   endtask

   task automatic wr(input logic [3:0] s, input logic [15:0] d);
      cmd(cpu_regs_pkg::OP_WR16, s, d, 0);
   endtask

   task automatic rdw(input logic [3:0] s, input logic [15:0] e);
      cmd(cpu_regs_pkg::OP_RD16, s, 16'h0000, s < 4'h4 ? 1 : 0);
      chk(rd, e);
   endtask

   task automatic t_regs();
      logic [15:0] w [7];
      for (int i = 0; i < 7; i++)
      begin
         w[i] = 16'h1e2d + 16'(i) * 16'h1111;
         wr(4'(i), w[i]);
      end
      for (int i = 0; i < 7; i++)
         rdw(4'(i), w[i]);
      for (int i = 0; i < 8; i++)
      begin
         cmd(cpu_regs_pkg::OP_RD8, 4'(i), 16'h0000, 1);
         chk(rd, {8'h00, i[0] ? w[i / 2][7:0] : w[i / 2][15:8]});
      end
      cmd(cpu_regs_pkg::OP_WR8, 4'h5, 16'h00c3, 0);
      rdw(cpu_regs_pkg::SEL16_DE, 16'h40c3);
      $display("regs test done");
   endtask

   task automatic t_bank();
      cmd(cpu_regs_pkg::OP_EXX, 4'h0, 16'h0000, 0);
      tick(1);
      chk({14'h0, bank}, 16'h0002);
      rdw(cpu_regs_pkg::SEL16_BC, 16'h0000);
      rdw(cpu_regs_pkg::SEL16_AF, 16'h1e2d);
      wr(cpu_regs_pkg::SEL16_BC, 16'hbeef);
      cmd(cpu_regs_pkg::OP_EX_AF, 4'h0, 16'h0000, 0);
      rdw(cpu_regs_pkg::SEL16_AF, 16'h0000);
      cmd(cpu_regs_pkg::OP_EXX, 4'h0, 16'h0000, 0);
      rdw(cpu_regs_pkg::SEL16_BC, 16'h2f3e);
      cmd(cpu_regs_pkg::OP_EX_AF, 4'h0, 16'h0000, 0);
      tick(1);
      chk({14'h0, bank}, 16'h0000);
      $display("bank test done");
   endtask

   task automatic t_stack();
      cmd(cpu_regs_pkg::OP_PUSH, 4'h0, 16'h0000, 0);
      chk(rd, 16'h626f);
      cmd(cpu_regs_pkg::OP_POP, 4'h0, 16'h0000, 0);
      chk(rd, 16'h626f);
      rdw(cpu_regs_pkg::SEL16_SP, 16'h6271);
      cmd(cpu_regs_pkg::OP_INDEX, 4'h0, 16'h0080, 0);
      chk(rd, 16'h7302);
      cmd(cpu_regs_pkg::OP_INDEX, 4'h1, 16'h007f, 0);
      chk(rd, 16'h8512);
      $display("stack test done");
   endtask

   task automatic t_int();
      logic [15:0] e;
      logic [15:0] sp;
      cmd(cpu_regs_pkg::OP_WR8, cpu_regs_pkg::SEL8_VEC_BASE, 16'h003a, 0);
      wr(cpu_regs_pkg::SEL16_PC, 16'h4000);
      sp = 16'h6271;
      for (int m = 0; m < 3; m++)
      begin
         cmd(cpu_regs_pkg::OP_INT_CFG, 4'h0, {13'h0, 1'b1, 2'(m)}, 0);
         @(posedge clk);
         raise_int <= 1'b1;
         tick(3);
         chk({15'h0, pend}, 16'h0001);
         cmd(cpu_regs_pkg::OP_INT_ACK, 4'h0, {8'h00, vec_lo}, 0);
         e = m == 0 ? {8'h00, vec_lo} : m == 1 ? cpu_regs_pkg::GENERIC_INT_ADDR : {8'h3a, vec_lo};
         chk(rd, e);
         chk(aux, 16'h4000);
         @(posedge clk);
         raise_int <= 1'b0;
         sp = sp - 16'h0002;
         tick(2);
         chk({15'h0, pend}, 16'h0000);
      end
      rdw(cpu_regs_pkg::SEL16_SP, sp);
      $display("interrupt test done");
   endtask

   task automatic t_refresh();
      cmd(cpu_regs_pkg::OP_WR8, cpu_regs_pkg::SEL8_REFRESH, 16'h00fe, 0);
      tick(2);
      chk(rfa, 16'h3afe);
      repeat (3)
      begin
         @(posedge clk);
         fetch_go <= 1'b1;
         @(posedge clk);
         fetch_go <= 1'b0;
      end
      tick(4);
      chk(rfa, 16'h3a81);
      $display("refresh test done");
   endtask

   task automatic t_bus();
      @(posedge clk);
      want_bus <= 1'b1;
      lat = 0;
      while (back_n !== 1'b0 && lat < 12)
      begin
         tick(1);
         lat++;
      end
      chk({15'h0, back_n}, 16'h0000);
      @(posedge clk);
      want_bus <= 1'b0;
      tick(3);
      chk({15'h0, back_n}, 16'h0001);
      $display("bus test done");
   endtask

   task automatic t_blk();
      wr(cpu_regs_pkg::SEL16_BC, 16'h0001);
      cmd(cpu_regs_pkg::OP_BLOCK, 4'h0, 16'h1e02, 7);
      chk(rd, 16'h5160);
      chk(aux, 16'h40c3);
      chk({14'h0, fm, fnz}, 16'h0002);
      cmd(cpu_regs_pkg::OP_BLOCK, 4'h0, 16'h0001, 7);
      chk(aux, 16'h40c3);
      chk({15'h0, fnz}, 16'h0001);
      cmd(cpu_regs_pkg::OP_BIT, 4'h4, 16'h0110, 0);
      chk({15'h0, fz}, 16'h0000);
      cmd(cpu_regs_pkg::OP_BIT, 4'h3, 16'h0110, 0);
      chk({15'h0, fz}, 16'h0001);
      cmd(cpu_regs_pkg::OP_BIT, 4'h0, 16'h0200, 0);
      chk({8'h00, rd[7:0]}, 16'h0001);
      cmd(cpu_regs_pkg::OP_BIT, 4'h7, 16'h03ff, 0);
      chk({8'h00, rd[7:0]}, 16'h007f);
      $display("block and bit test done");
   endtask

   initial
   begin
      rst = 1'b1;
      valid = 1'b0;
      op = 4'h0;
      sel = 4'h0;
      dat = 16'h0000;
      want_bus = 1'b0;
      raise_int = 1'b0;
      fetch_go = 1'b0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      tick(2);
      t_regs();
      t_bank();
      t_stack();
      t_int();
      t_refresh();
      t_bus();
      t_blk();
      final_report();
   end
endmodule
`default_nettype wire
